// [ctru_defs.svh]
// Constants for the counter, timeout, delay and reset helper block
`ifndef CTRU_DEFS_SVH
`define CTRU_DEFS_SVH

// ==========================================================
// Clock
`define CTRU_CLK_FREQ_HZ 100000000
`define CTRU_CYC_PER_US (`CTRU_CLK_FREQ_HZ / 1000000)

// ==========================================================
// Register map (byte addresses)
`define CTRU_ADDR_W 8
`define CTRU_OFF_CTRL 8'h00
`define CTRU_OFF_STATE_TOTAL 8'h04
`define CTRU_OFF_WIDTH_BITS 8'h08
`define CTRU_OFF_COUNT 8'h0c
`define CTRU_OFF_FREE 8'h10
`define CTRU_OFF_TO_LIMIT 8'h14
`define CTRU_OFF_TO_STAT 8'h18
`define CTRU_OFF_HISTORY 8'h1c

// CTRL fields
`define CTRU_CTRL_CLEAR 0
`define CTRU_CTRL_MODE_WIDTH 1
`define CTRU_CTRL_TO_TIME 2
// COUNT read fields
`define CTRU_CNT_WRAP 16
`define CTRU_CNT_WOULD 17
// TO_STAT fields
`define CTRU_TO_TICK 0

// ==========================================================
// Sizes and reset values
`define CTRU_CNT_W 16
`define CTRU_WBITS_W 5
`define CTRU_DATA_W 8
`define CTRU_DELAY_CYCLES 4
`define CTRU_HIST_LEN 4
`define CTRU_SYNC_STAGES 2
`define CTRU_STATE_TOTAL_RST 16'h000a
`define CTRU_WIDTH_BITS_RST 5'h04
`define CTRU_TO_LIMIT_RST 32'h00000010

// ==========================================================
// Reset filter levels
`define CTRU_IN_RESET_LEVEL 1'b1
`define CTRU_OUT_RESET_LEVEL 1'b1

`endif

// [ctru_pkg.sv]
// Types shared by the helper block
package ctru_pkg;
	`include "ctru_defs.svh"

	typedef struct packed {
		logic [`CTRU_ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} ctru_avs_req_s;

	typedef enum logic {
		CTRU_BUS_IDLE,
		CTRU_BUS_ACK
	} ctru_bus_e;
endpackage : ctru_pkg

// [ctru_top.sv]
// Counter, free counter, timeout, delay, history, synchroniser and reset filters
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`include "ctru_defs.svh"

module ctru_top (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire ctru_pkg::ctru_avs_req_s i_avs,
	input wire logic i_step,
	input wire logic [`CTRU_DATA_W-1:0] i_delay_in,
	input wire logic [`CTRU_DATA_W-1:0] i_hist_in,
	input wire logic i_hist_en,
	input wire logic i_async_in,
	input wire logic i_raw_rst,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [`CTRU_DATA_W-1:0] o_delay_out,
	output logic o_sync_out,
	output logic o_rst_filt,
	output logic o_timeout_tick
);

	// ==========================================================
	// Functions
	function automatic logic [`CTRU_CNT_W-1:0] width_end(input logic [`CTRU_WBITS_W-1:0] w);
		width_end = (w >= `CTRU_WBITS_W'(`CTRU_CNT_W)) ? '1 :
			`CTRU_CNT_W'((17'h00001 << w) - 17'h00001);
	endfunction : width_end

	function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		merge_be = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge_be[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction : merge_be

	// ==========================================================
	// Drive variant reset filter for this domain
	logic [`CTRU_SYNC_STAGES-1:0] int_rst_chain_reg;
	logic rst_int_n;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_rst_chain_reg <= '0;
		end else begin
			int_rst_chain_reg <= {int_rst_chain_reg[`CTRU_SYNC_STAGES-2:0], 1'b1};
		end
	end
	assign rst_int_n = int_rst_chain_reg[`CTRU_SYNC_STAGES-1];

	// ==========================================================
	// Returned reset filter with configurable levels
	logic raw_active;
	logic [`CTRU_SYNC_STAGES-1:0] rst_chain_reg;

	assign raw_active = (i_raw_rst == `CTRU_IN_RESET_LEVEL);

	always_ff @(posedge i_ref_clk or posedge raw_active) begin
		if (raw_active) begin
			rst_chain_reg <= {`CTRU_SYNC_STAGES{`CTRU_OUT_RESET_LEVEL}};
		end else begin
			rst_chain_reg <= {rst_chain_reg[`CTRU_SYNC_STAGES-2:0], ~`CTRU_OUT_RESET_LEVEL};
		end
	end
	assign o_rst_filt = rst_chain_reg[`CTRU_SYNC_STAGES-1];

	// ==========================================================
	// Two-flop synchroniser
	logic [1:0] sync_reg;

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= {sync_reg[0], i_async_in};
		end
	end
	assign o_sync_out = sync_reg[1];

	// ==========================================================
	// Delay line
	logic [`CTRU_DATA_W-1:0] delay_reg [`CTRU_DELAY_CYCLES];

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			for (int i = 0; i < `CTRU_DELAY_CYCLES; i++) begin
				delay_reg[i] <= '0;
			end
		end else begin
			delay_reg[0] <= i_delay_in;
			for (int i = 1; i < `CTRU_DELAY_CYCLES; i++) begin
				delay_reg[i] <= delay_reg[i-1];
			end
		end
	end
	assign o_delay_out = delay_reg[`CTRU_DELAY_CYCLES-1];

	// ==========================================================
	// History; entry zero is the live input
	logic [`CTRU_DATA_W-1:0] hist_reg [`CTRU_HIST_LEN-1];
	logic [`CTRU_HIST_LEN*`CTRU_DATA_W-1:0] history;

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			for (int i = 0; i < `CTRU_HIST_LEN-1; i++) begin
				hist_reg[i] <= '0;
			end
		end else if (i_hist_en) begin
			hist_reg[0] <= i_hist_in;
			for (int i = 1; i < `CTRU_HIST_LEN-1; i++) begin
				hist_reg[i] <= hist_reg[i-1];
			end
		end
	end

	always_comb begin
		history[`CTRU_DATA_W-1:0] = i_hist_in;
		for (int i = 1; i < `CTRU_HIST_LEN; i++) begin
			history[i*`CTRU_DATA_W +: `CTRU_DATA_W] = hist_reg[i-1];
		end
	end

	// ==========================================================
	// Registers written by software
	logic mode_width_reg;
	logic to_time_reg;
	logic [`CTRU_CNT_W-1:0] state_total_reg;
	logic [`CTRU_WBITS_W-1:0] width_bits_reg;
	logic [31:0] to_limit_reg;
	logic wr_acc;
	logic clear_pulse;
	logic tick_clear;

	assign wr_acc = i_avs.write && !o_avs_waitrequest;
	assign clear_pulse = wr_acc && i_avs.address == `CTRU_OFF_CTRL && i_avs.byteenable[0] &&
		i_avs.writedata[`CTRU_CTRL_CLEAR];
	assign tick_clear = wr_acc && i_avs.address == `CTRU_OFF_TO_STAT &&
		i_avs.byteenable[0] && i_avs.writedata[`CTRU_TO_TICK];

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			mode_width_reg <= 1'b0;
			to_time_reg <= 1'b0;
			state_total_reg <= `CTRU_STATE_TOTAL_RST;
			width_bits_reg <= `CTRU_WIDTH_BITS_RST;
			to_limit_reg <= `CTRU_TO_LIMIT_RST;
		end else if (wr_acc) begin
			case (i_avs.address)
				`CTRU_OFF_CTRL: begin
					if (i_avs.byteenable[0]) begin
						mode_width_reg <= i_avs.writedata[`CTRU_CTRL_MODE_WIDTH];
						to_time_reg <= i_avs.writedata[`CTRU_CTRL_TO_TIME];
					end
				end
				`CTRU_OFF_STATE_TOTAL: begin
					state_total_reg <= `CTRU_CNT_W'(merge_be({16'h0000, state_total_reg},
						i_avs.writedata, i_avs.byteenable));
				end
				`CTRU_OFF_WIDTH_BITS: begin
					if (i_avs.byteenable[0]) begin
						width_bits_reg <= i_avs.writedata[`CTRU_WBITS_W-1:0];
					end
				end
				`CTRU_OFF_TO_LIMIT: begin
					to_limit_reg <= merge_be(to_limit_reg, i_avs.writedata, i_avs.byteenable);
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Up counter
	logic [`CTRU_CNT_W-1:0] count_reg;
	logic [`CTRU_CNT_W-1:0] next_count;
	logic [`CTRU_CNT_W-1:0] end_value;
	logic would_wrap_flag;
	logic wrap_flag;

	assign end_value = mode_width_reg ? width_end(width_bits_reg) :
		state_total_reg - `CTRU_CNT_W'(1);
	assign would_wrap_flag = (count_reg == end_value);
	assign wrap_flag = would_wrap_flag && i_step;

	always_comb begin
		if (clear_pulse) begin
			next_count = '0;
		end else if (wrap_flag) begin
			next_count = '0;
		end else if (i_step) begin
			next_count = count_reg + `CTRU_CNT_W'(1);
		end else begin
			next_count = count_reg;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= next_count;
		end
	end

	// ==========================================================
	// Free-running counter
	logic [`CTRU_CNT_W-1:0] free_reg;

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			free_reg <= '0;
		end else if (free_reg >= state_total_reg - `CTRU_CNT_W'(1)) begin
			free_reg <= '0;
		end else begin
			free_reg <= free_reg + `CTRU_CNT_W'(1);
		end
	end

	// ==========================================================
	// Timeout; limit in cycles or in microseconds
	logic [31:0] to_cnt_reg;
	logic [31:0] to_cycles;

	assign to_cycles = to_time_reg ? 32'(to_limit_reg * `CTRU_CYC_PER_US) : to_limit_reg;

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			to_cnt_reg <= '0;
		end else if (tick_clear) begin
			to_cnt_reg <= '0;
		end else if (!o_timeout_tick) begin
			to_cnt_reg <= to_cnt_reg + 32'h00000001;
		end
	end

	// Set beats a clear landing in the same cycle
	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			o_timeout_tick <= 1'b0;
		end else if (!o_timeout_tick && to_cnt_reg + 32'h00000001 >= to_cycles) begin
			o_timeout_tick <= 1'b1;
		end else if (tick_clear) begin
			o_timeout_tick <= 1'b0;
		end
	end

	// ==========================================================
	// Avalon slave: one wait cycle, then one ready cycle
	ctru_pkg::ctru_bus_e bus_state_reg;

	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			bus_state_reg <= ctru_pkg::CTRU_BUS_IDLE;
			o_avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state_reg)
				ctru_pkg::CTRU_BUS_IDLE: begin
					if (i_avs.read || i_avs.write) begin
						bus_state_reg <= ctru_pkg::CTRU_BUS_ACK;
						o_avs_waitrequest <= 1'b0;
					end
				end
				ctru_pkg::CTRU_BUS_ACK: begin
					bus_state_reg <= ctru_pkg::CTRU_BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state_reg <= ctru_pkg::CTRU_BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Data is captured one cycle early and held across the ready cycle
	always_ff @(posedge i_ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			o_avs_readdata <= '0;
		end else if (i_avs.read && bus_state_reg == ctru_pkg::CTRU_BUS_IDLE) begin
			case (i_avs.address)
				`CTRU_OFF_CTRL: o_avs_readdata <= 32'({to_time_reg, mode_width_reg, 1'b0});
				`CTRU_OFF_STATE_TOTAL: o_avs_readdata <= 32'(state_total_reg);
				`CTRU_OFF_WIDTH_BITS: o_avs_readdata <= 32'(width_bits_reg);
				`CTRU_OFF_COUNT: o_avs_readdata <= 32'({would_wrap_flag, wrap_flag, count_reg});
				`CTRU_OFF_FREE: o_avs_readdata <= 32'(free_reg);
				`CTRU_OFF_TO_LIMIT: o_avs_readdata <= to_limit_reg;
				`CTRU_OFF_TO_STAT: o_avs_readdata <= 32'(o_timeout_tick);
				`CTRU_OFF_HISTORY: o_avs_readdata <= history;
				default: o_avs_readdata <= '0;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	property p_delay;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		$past(rst_int_n, `CTRU_DELAY_CYCLES)
			|-> o_delay_out == $past(i_delay_in, `CTRU_DELAY_CYCLES);
	endproperty
	a_delay: assert property (p_delay) else $error("Delay output mismatch");

	property p_hist_shift;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		i_hist_en |=> history[2*`CTRU_DATA_W-1:`CTRU_DATA_W] == $past(i_hist_in);
	endproperty
	a_hist_shift: assert property (p_hist_shift) else $error("History did not shift");

	property p_hist_hold;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		!i_hist_en |=> $stable(history[`CTRU_HIST_LEN*`CTRU_DATA_W-1:`CTRU_DATA_W]);
	endproperty
	a_hist_hold: assert property (p_hist_hold) else $error("History moved without enable");

	property p_sync;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		$past(rst_int_n, 2) |-> o_sync_out == $past(i_async_in, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("Synchroniser latency wrong");

	property p_clear;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		clear_pulse |=> count_reg == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("Clear did not zero count");

	property p_step;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		i_step && !clear_pulse && !would_wrap_flag |=> count_reg == $past(count_reg) + 16'h0001;
	endproperty
	a_step: assert property (p_step) else $error("Step did not add one");

	property p_hold;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		!i_step && !clear_pulse |=> $stable(count_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("Count moved without step");

	property p_wrap;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		wrap_flag && !clear_pulse |=> count_reg == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Wrap did not reload start");

	property p_would;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		wrap_flag |-> would_wrap_flag && count_reg == end_value;
	endproperty
	a_would: assert property (p_would) else $error("Wrap without end value");

	property p_free;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		free_reg < state_total_reg - 16'h0001 && $stable(state_total_reg)
			|=> free_reg == $past(free_reg) + 16'h0001;
	endproperty
	a_free: assert property (p_free) else $error("Free counter did not step");

	property p_tick_sticky;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		o_timeout_tick && !tick_clear |=> o_timeout_tick;
	endproperty
	a_tick_sticky: assert property (p_tick_sticky) else $error("Tick dropped uncleared");

	property p_tick_set;
		@(posedge i_ref_clk) disable iff (!rst_int_n)
		!o_timeout_tick && to_cnt_reg + 32'h00000001 >= to_cycles |=> o_timeout_tick;
	endproperty
	a_tick_set: assert property (p_tick_set) else $error("Tick not raised at limit");

	property p_rst_release;
		@(posedge i_ref_clk)
		raw_active |=> o_rst_filt == `CTRU_OUT_RESET_LEVEL;
	endproperty
	a_rst_release: assert property (p_rst_release) else $error("Filter released early");

endmodule : ctru_top

// [ctru_user_model.sv]
// Model of the surrounding user logic feeding the delay and history paths
module ctru_user_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_hist_en,
	output logic [7:0] o_delay_in,
	output logic [7:0] o_hist_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Sources
	// Odd step so a stuck or misaligned stage never looks right
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_delay_in <= 8'h00;
		end else begin
			o_delay_in <= o_delay_in + 8'h03;
		end
	end
	// New sample only when the consumer is told to take one
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hist_in <= 8'h40;
		end else if (i_hist_en) begin
			o_hist_in <= o_hist_in + 8'h01;
		end
	end
endmodule : ctru_user_model

// [ctru_top_tb.sv]
// Self-checking bench for the counter, timeout, delay and reset helpers
`include "ctru_defs.svh"
module ctru_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [7:0] addr;
		logic [3:0] be;
		logic we;
		logic [31:0] wd;
		logic [31:0] exp;
	} ctru_row_s;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	ctru_pkg::ctru_avs_req_s i_avs = '0;
	logic i_step = 1'b0;
	logic i_hist_en = 1'b0;
	logic i_async_in = 1'b0;
	logic i_raw_rst = 1'b0;
	logic [7:0] delay_in;
	logic [7:0] hist_in;
	logic [7:0] v;
	logic [31:0] o_avs_readdata;
	logic [31:0] rd;
	logic [31:0] f1;
	logic [7:0] o_delay_out;
	logic o_avs_waitrequest;
	logic o_sync_out;
	logic o_rst_filt;
	logic o_timeout_tick;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	ctru_row_s rows [8];

	always #5 i_ref_clk = ~i_ref_clk;

	ctru_top u_ctru_top (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_avs(i_avs),
		.i_step(i_step),
		.i_delay_in(delay_in),
		.i_hist_in(hist_in),
		.i_hist_en(i_hist_en),
		.i_async_in(i_async_in),
		.i_raw_rst(i_raw_rst),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_delay_out(o_delay_out),
		.o_sync_out(o_sync_out),
		.o_rst_filt(o_rst_filt),
		.o_timeout_tick(o_timeout_tick)
	);

	ctru_user_model u_ctru_user_model (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_hist_en(i_hist_en),
		.o_delay_in(delay_in),
		.o_hist_in(hist_in)
	);

	// ==========================================================
	// Helpers
	task automatic conclude();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Step may ride along with the request to land on the sampling edge
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be, input logic stp, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge i_ref_clk);
		i_avs <= '{address: a, read: !we, write: we, writedata: d, byteenable: be};
		i_step <= stp;
		do begin
			@(posedge i_ref_clk);
			k++;
		end while (o_avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) n_fail++;
		q = o_avs_readdata;
		i_avs <= '0;
		i_step <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf, 1'b0, rd);
	endtask : wr

	task automatic rdx(input logic [7:0] a, input logic stp, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf, stp, rd);
		check(rd, exp);
	endtask : rdx

	task automatic steps(input int cnt);
		@(posedge i_ref_clk);
		i_step <= 1'b1;
		repeat (cnt) @(posedge i_ref_clk);
		i_step <= 1'b0;
	endtask : steps

	// Edges after a cleared timeout until the tick shows
	task automatic tick_wait();
		n = 0;
		do begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end while (o_timeout_tick !== 1'b1 && n < 300);
	endtask : tick_wait

	// ==========================================================
	// Hang guard
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end

	// ==========================================================
	// Sequence
	initial begin
		rows = '{
			'{`CTRU_OFF_CTRL, 4'hf, 1'b0, 32'h0, 32'h0},
			'{`CTRU_OFF_STATE_TOTAL, 4'hf, 1'b0, 32'h0, 32'h0000000a},
			'{`CTRU_OFF_WIDTH_BITS, 4'hf, 1'b0, 32'h0, 32'h00000004},
			'{`CTRU_OFF_TO_LIMIT, 4'hf, 1'b0, 32'h0, 32'h00000010},
			'{`CTRU_OFF_COUNT, 4'hf, 1'b0, 32'h0, 32'h0},
			'{8'h20, 4'hf, 1'b1, 32'hffffffff, 32'h0},
			'{`CTRU_OFF_WIDTH_BITS, 4'hf, 1'b1, 32'h000000ff, 32'h0000001f},
			'{`CTRU_OFF_STATE_TOTAL, 4'h1, 1'b1, 32'h00001207, 32'h00000007}
		};
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		bus(1'b0, `CTRU_OFF_FREE, 32'h0, 4'hf, 1'b0, f1);
		bus(1'b0, `CTRU_OFF_FREE, 32'h0, 4'hf, 1'b0, rd);
		check((rd + 32'h0a - f1) % 32'h0a, 32'h3);
		foreach (rows[i]) begin
			if (rows[i].we) bus(1'b1, rows[i].addr, rows[i].wd, rows[i].be, 1'b0, rd);
			bus(1'b0, rows[i].addr, 32'h0, 4'hf, 1'b0, rd);
			check(rd, rows[i].exp);
		end
		// Counter over a state total of seven, then over two width bits
		wr(`CTRU_OFF_CTRL, 32'h1);
		steps(6);
		rdx(`CTRU_OFF_COUNT, 1'b0, 32'h00020006);
		rdx(`CTRU_OFF_COUNT, 1'b1, 32'h00030006);
		rdx(`CTRU_OFF_COUNT, 1'b0, 32'h00000001);
		wr(`CTRU_OFF_WIDTH_BITS, 32'h2);
		wr(`CTRU_OFF_CTRL, 32'h3);
		steps(3);
		rdx(`CTRU_OFF_COUNT, 1'b0, 32'h00020003);
		steps(1);
		rdx(`CTRU_OFF_COUNT, 1'b0, 32'h0);
		// Timeout in cycles, then in microseconds
		rdx(`CTRU_OFF_TO_STAT, 1'b0, 32'h1);
		wr(`CTRU_OFF_TO_LIMIT, 32'h14);
		wr(`CTRU_OFF_TO_STAT, 32'h1);
		tick_wait();
		check(n, 32'h14);
		repeat (30) @(posedge i_ref_clk);
		check({31'h0, o_timeout_tick}, 32'h1);
		wr(`CTRU_OFF_TO_LIMIT, 32'h1);
		wr(`CTRU_OFF_CTRL, 32'h4);
		wr(`CTRU_OFF_TO_STAT, 32'h1);
		tick_wait();
		check(n, 32'h64);
		// Delay line and sample history
		@(posedge i_ref_clk);
		i_hist_en <= 1'b1;
		repeat (12) @(posedge i_ref_clk);
		repeat (4) begin
			@(posedge i_ref_clk);
			#1;
			check({24'h0, o_delay_out}, {24'h0, delay_in - 8'h0c});
		end
		@(posedge i_ref_clk);
		i_hist_en <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
		v = hist_in;
		rdx(`CTRU_OFF_HISTORY, 1'b0, {v - 8'h03, v - 8'h02, v - 8'h01, v});
		// Foreign-domain input
		@(posedge i_ref_clk);
		i_async_in <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		check({31'h0, o_sync_out}, 32'h0);
		@(posedge i_ref_clk);
		#1;
		check({31'h0, o_sync_out}, 32'h1);
		// Returned reset filter
		check({31'h0, o_rst_filt}, 32'h0);
		@(posedge i_ref_clk);
		i_raw_rst <= 1'b1;
		#1;
		check({31'h0, o_rst_filt}, 32'h1);
		repeat (3) @(posedge i_ref_clk);
		i_raw_rst <= 1'b0;
		@(posedge i_ref_clk);
		#1;
		check({31'h0, o_rst_filt}, 32'h1);
		@(posedge i_ref_clk);
		#1;
		check({31'h0, o_rst_filt}, 32'h0);
		// Mid-run reset through the driving filter
		@(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		#1;
		check({o_avs_waitrequest, o_timeout_tick, o_delay_out}, 32'h200);
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		rdx(`CTRU_OFF_STATE_TOTAL, 1'b0, 32'h0000000a);
		conclude();
	end
endmodule : ctru_top_tb
